// [core/ardt_pkg.sv]
// Shared constants and types of the receiver data timing block
package ardt_pkg;
    // ==========================================================
    // Clock and base tick
    localparam int CLK_PERIOD_NS = 100;
    localparam logic [3:0] DIV_PLAN_LOW = 4'hA;
    localparam logic [3:0] DIV_PLAN_HIGH = 4'hE;
    // Crystal and tick figures per frequency plan, kept for reference
    localparam real XTAL_MHZ_LOW = 4.90625;
    localparam real TICK_US_LOW = 2.0383;
    localparam real XTAL_MHZ_HIGH = 6.76438;
    localparam real TICK_US_HIGH = 2.0697;

    // ==========================================================
    // Rate ranges and extended tick
    localparam logic [1:0] RANGE_0 = 2'h0;
    localparam logic [1:0] RANGE_1 = 2'h1;
    localparam logic [1:0] RANGE_2 = 2'h2;
    localparam logic [1:0] RANGE_3 = 2'h3;
    localparam logic [3:0] XT_DIV_R0 = 4'h8;
    localparam logic [3:0] XT_DIV_R1 = 4'h4;
    localparam logic [3:0] XT_DIV_R2 = 4'h2;
    localparam logic [3:0] XT_DIV_R3 = 4'h1;

    // Settle time in half base ticks (896.5, 512.5, 512.5, 320.5 ticks)
    localparam logic [11:0] SETTLE_HALF_R0 = 12'h701;
    localparam logic [11:0] SETTLE_HALF_R1 = 12'h401;
    localparam logic [11:0] SETTLE_HALF_R2 = 12'h401;
    localparam logic [11:0] SETTLE_HALF_R3 = 12'h281;

    // Least edge-to-edge gap on the data output, in extended ticks
    localparam logic [14:0] MIN_GAP_XT = 15'h0002;
    localparam logic [14:0] GAP_MAX = 15'h7FFF;

    // ==========================================================
    // Register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_EDGE = 4'h8;
    localparam int CTRL_FORCE_R3 = 0;
    localparam int ST_MODE = 0;
    localparam int ST_RANGE = 2;
    localparam int ST_DATA = 4;
    localparam int ST_OVF = 5;
    localparam int ST_AVAIL = 6;
    localparam int EDGE_VALID = 16;
    localparam logic CTRL_RESET = 1'b0;
    localparam logic IDLE_LEVEL = 1'b1;

    // ==========================================================
    // Edge interval buffer
    localparam int EDGE_W = 16;
    localparam int EDGE_DEPTH = 8;

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_SETTLE,
        MODE_SEEK,
        MODE_RECV
    } ardt_mode_type;
endpackage

// [core/ardt_fifo.sv]
// Synchronous FIFO with valid and ready on both sides
module ardt_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;
    logic push, pop;

    // ==========================================================
    // Pointers
    always_comb begin
        in_ready = (level != DEPTH[AW:0]);
        out_valid = (wp_q != rp_q);
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
    end

    assign level = wp_q - rp_q;
    assign out_data = mem_q[rp_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end

    AST_FIFO_BOUND: assert property (@(posedge clk) disable iff (sys_rst)
        level <= DEPTH[AW:0])
        else $error("FIFO level beyond depth");
endmodule

// [core/ardt_rx_timing.sv]
// Data timing back end of an ASK receiver: ticks, wake sequence, output shaping
// What this block does, and what [R14] [R15] ask of the controller and transmitter
// [R1] Decode rate pins into range 0,1,2
// [R2] Extended tick is 8,4,2,1 base ticks
// [R3] Base tick divides crystal, plan pin selects
// [R4] Divide by 10 low, 14 high
// [R5] Tick 2.0383us or 2.0697us at nominal crystals
// [R6] Enable low holds sleep, input ignored
// [R7] Enable high starts range-dependent settle period
// [R8] Settle 896.5/512.5/512.5/320.5 base ticks
// [R9] After settle, demodulator drives data output
// [R10] Output starts on first demodulator falling edge
// [R11] Receiving lasts until enable goes low
// [R12] Output resampled, changes only on extended ticks
// [R13] Output edges never closer than minimum gap
// [R14] Controller picks range matching actual baud
// [R15] Transmitter keeps edge intervals within limits
module ardt_rx_timing #(
    parameter logic [11:0] SETTLE_HALF_0 = ardt_pkg::SETTLE_HALF_R0,
    parameter logic [11:0] SETTLE_HALF_1 = ardt_pkg::SETTLE_HALF_R1,
    parameter logic [11:0] SETTLE_HALF_2 = ardt_pkg::SETTLE_HALF_R2,
    parameter logic [11:0] SETTLE_HALF_3 = ardt_pkg::SETTLE_HALF_R3
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enable_pin,
    input wire logic freq_plan,
    input wire logic rate_sel_lo,
    input wire logic rate_sel_hi,
    input wire logic dem_in,
    output logic data_out,
    output logic rx_active,
    output logic base_tick,
    output logic extended_tick,
    input wire logic [ardt_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ardt_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ardt_pkg::DATA_W-1:0] reg_rdata
);
    import ardt_pkg::*;

    // ==========================================================
    // Base tick and extended tick
    logic [3:0] div, xdiv;
    logic [3:0] bcnt_q, bcnt_d;
    logic [3:0] xcnt_q, xcnt_d;
    logic [1:0] rate_range;
    logic force_r3_q, force_r3_d;
    ardt_mode_type mode_q, mode_d;

    always_comb begin
        div = freq_plan ? DIV_PLAN_HIGH : DIV_PLAN_LOW; // see [R4] [R5]
        if (force_r3_q) begin
            rate_range = RANGE_3;
        end else if (rate_sel_hi) begin
            rate_range = RANGE_2; // see [R1]
        end else if (rate_sel_lo) begin
            rate_range = RANGE_1;
        end else begin
            rate_range = RANGE_0;
        end
        unique case (rate_range)
            RANGE_0: xdiv = XT_DIV_R0; // see [R2]
            RANGE_1: xdiv = XT_DIV_R1;
            RANGE_2: xdiv = XT_DIV_R2;
            RANGE_3: xdiv = XT_DIV_R3;
        endcase
        // The divider keeps running in sleep, like the oscillator behind it
        base_tick = (bcnt_q >= div - 4'h1); // see [R3]
        bcnt_d = base_tick ? 4'h0 : bcnt_q + 4'h1;
        extended_tick = base_tick && (xcnt_q >= xdiv - 4'h1) && (mode_q != MODE_SLEEP);
        if (mode_q == MODE_SLEEP) begin
            xcnt_d = 4'h0;
        end else if (extended_tick) begin
            xcnt_d = 4'h0;
        end else if (base_tick) begin
            xcnt_d = xcnt_q + 4'h1;
        end else begin
            xcnt_d = xcnt_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bcnt_q <= 4'h0;
            xcnt_q <= 4'h0;
        end else begin
            bcnt_q <= bcnt_d;
            xcnt_q <= xcnt_d;
        end
    end

    // ==========================================================
    // Wake sequence and output shaping
    logic [11:0] settle_half;
    logic [15:0] settle_prod, settle_target;
    logic [15:0] scnt_q, scnt_d;
    logic samp_q, samp_d;
    logic out_q, out_d;
    logic [14:0] gap_q, gap_d, elapsed;
    logic edge_ev;

    always_comb begin
        unique case (rate_range)
            RANGE_0: settle_half = SETTLE_HALF_0; // see [R8]
            RANGE_1: settle_half = SETTLE_HALF_1;
            RANGE_2: settle_half = SETTLE_HALF_2;
            RANGE_3: settle_half = SETTLE_HALF_3;
        endcase
        // Half-tick figures times the divider are always whole clock cycles
        settle_prod = 16'(settle_half) * 16'(div);
        settle_target = {1'b0, settle_prod[15:1]};
        elapsed = (gap_q == GAP_MAX) ? GAP_MAX : gap_q + 15'h1;
        mode_d = mode_q;
        scnt_d = scnt_q;
        samp_d = extended_tick ? dem_in : samp_q; // see [R12]
        out_d = out_q;
        gap_d = gap_q;
        edge_ev = 1'b0;
        unique case (mode_q)
            MODE_SLEEP: begin
                out_d = IDLE_LEVEL; // see [R6]
                samp_d = IDLE_LEVEL;
                if (enable_pin) begin
                    mode_d = MODE_SETTLE; // see [R7]
                    scnt_d = 16'h0;
                end
            end
            MODE_SETTLE: begin
                scnt_d = scnt_q + 16'h1;
                if (scnt_q >= settle_target - 16'h1) begin
                    mode_d = MODE_SEEK; // see [R9]
                end
            end
            MODE_SEEK: begin
                if (extended_tick && samp_q && !dem_in) begin
                    mode_d = MODE_RECV; // see [R10]
                    out_d = 1'b0;
                    gap_d = 15'h0;
                end
            end
            MODE_RECV: begin
                if (extended_tick) begin
                    // A one-tick spike seen on the first tick after an output edge never reaches the pin
                    if (dem_in != out_q && elapsed >= MIN_GAP_XT) begin
                        out_d = dem_in; // see [R13]
                        gap_d = 15'h0;
                        edge_ev = 1'b1;
                    end else begin
                        gap_d = elapsed;
                    end
                end
            end
        endcase
        if (!enable_pin) begin
            mode_d = MODE_SLEEP; // see [R11]
            // Idle level at once, so the drop to idle is never logged as an edge
            out_d = IDLE_LEVEL;
            edge_ev = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_q <= MODE_SLEEP;
            scnt_q <= 16'h0;
            samp_q <= IDLE_LEVEL;
            out_q <= IDLE_LEVEL;
            gap_q <= 15'h0;
        end else begin
            mode_q <= mode_d;
            scnt_q <= scnt_d;
            samp_q <= samp_d;
            out_q <= out_d;
            gap_q <= gap_d;
        end
    end

    assign data_out = out_q;
    assign rx_active = (mode_q == MODE_RECV);

    // ==========================================================
    // Edge interval logging through the buffer
    logic pend_valid_q, pend_valid_d;
    logic [EDGE_W-1:0] pend_word_q, pend_word_d;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [EDGE_W-1:0] fifo_out_data;
    logic ovf_q, ovf_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0] mode_code;

    ardt_fifo #(
        .WIDTH(EDGE_W),
        .DEPTH(EDGE_DEPTH)
    ) u_edge_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(pend_valid_q),
        .in_ready(fifo_in_ready),
        .in_data(pend_word_q),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data),
        .level()
    );

    always_comb begin
        // A full buffer stalls the pending word; a newer edge is then dropped
        pend_valid_d = pend_valid_q && !fifo_in_ready;
        pend_word_d = pend_word_q;
        ovf_d = ovf_q;
        if (reg_wr && reg_addr == OFS_STATUS && reg_wdata[ST_OVF]) begin
            ovf_d = 1'b0;
        end
        if (edge_ev) begin
            if (pend_valid_d) begin
                ovf_d = 1'b1;
            end else begin
                pend_word_d = {out_d, elapsed};
                pend_valid_d = 1'b1;
            end
        end
        force_r3_d = force_r3_q;
        if (reg_wr && reg_addr == OFS_CTRL) begin
            force_r3_d = reg_wdata[CTRL_FORCE_R3];
        end
        unique case (mode_q)
            MODE_SLEEP: mode_code = 2'h0;
            MODE_SETTLE: mode_code = 2'h1;
            MODE_SEEK: mode_code = 2'h2;
            MODE_RECV: mode_code = 2'h3;
        endcase
        fifo_pop = reg_rd && reg_addr == OFS_EDGE;
        rdata_d = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_CTRL: rdata_d[CTRL_FORCE_R3] = force_r3_q;
                OFS_STATUS: begin
                    rdata_d[ST_MODE +: 2] = mode_code;
                    rdata_d[ST_RANGE +: 2] = rate_range;
                    rdata_d[ST_DATA] = out_q;
                    rdata_d[ST_OVF] = ovf_q;
                    rdata_d[ST_AVAIL] = fifo_out_valid;
                end
                OFS_EDGE: begin
                    rdata_d[EDGE_W-1:0] = fifo_out_valid ? fifo_out_data : '0;
                    rdata_d[EDGE_VALID] = fifo_out_valid;
                end
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pend_valid_q <= 1'b0;
            pend_word_q <= '0;
            ovf_q <= 1'b0;
            force_r3_q <= CTRL_RESET;
            rdata_q <= '0;
        end else begin
            pend_valid_q <= pend_valid_d;
            pend_word_q <= pend_word_d;
            ovf_q <= ovf_d;
            force_r3_q <= force_r3_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ==========================================================
    // Checks
    logic [7:0] bgap_q, xgap_q, xsince_q;
    logic seen_q, calm_q, fp_q, dprev_q;
    logic [1:0] rr_q;
    // Extended tick spacing is only judged over intervals with no plan or range change; base tick spacing only needs the plan steady at the tick
    always_ff @(posedge clk) begin
        rr_q <= rate_range;
        fp_q <= freq_plan;
        if (sys_rst || !enable_pin) begin
            bgap_q <= 8'h0;
            xgap_q <= 8'h0;
            seen_q <= 1'b0;
            calm_q <= 1'b0;
            xsince_q <= 8'h0;
            dprev_q <= IDLE_LEVEL;
        end else begin
            bgap_q <= base_tick ? 8'h0 : bgap_q + 8'h1;
            xgap_q <= extended_tick ? 8'h0 : xgap_q + 8'h1;
            seen_q <= seen_q || extended_tick;
            calm_q <= extended_tick || (calm_q && rate_range == rr_q && freq_plan == fp_q);
            dprev_q <= data_out;
            if (data_out != dprev_q) begin
                xsince_q <= 8'(extended_tick);
            end else if (extended_tick && xsince_q != 8'hFF) begin
                xsince_q <= xsince_q + 8'h1;
            end
        end
    end

    AST_RANGE_DECODE: assert property (@(posedge clk) disable iff (sys_rst) // see [R1]
        !force_r3_q |-> rate_range == (rate_sel_hi ? 2'h2 : {1'b0, rate_sel_lo}))
        else $error("Rate range decode wrong");
    AST_BASE_DIV: assert property (@(posedge clk) disable iff (sys_rst) // see [R4]
        base_tick && $stable(freq_plan) && seen_q |-> bgap_q == 8'(div) - 8'h1)
        else $error("Base tick spacing wrong");
    AST_XTICK_PERIOD: assert property (@(posedge clk) disable iff (sys_rst) // see [R2]
        extended_tick && seen_q && calm_q && rate_range == rr_q && freq_plan == fp_q
        && $past(mode_q) != MODE_SLEEP |-> xgap_q == 8'(xdiv) * 8'(div) - 8'h1)
        else $error("Extended tick spacing wrong");
    AST_SLEEP: assert property (@(posedge clk) disable iff (sys_rst) // see [R6]
        !enable_pin |=> mode_q == MODE_SLEEP && data_out == IDLE_LEVEL)
        else $error("Not asleep after enable low");
    AST_WAKE: assert property (@(posedge clk) disable iff (sys_rst) // see [R7]
        mode_q == MODE_SLEEP && enable_pin |=> mode_q == MODE_SETTLE && scnt_q == 16'h0)
        else $error("Wake did not start settling");
    AST_SETTLE_LEN: assert property (@(posedge clk) disable iff (sys_rst) // see [R8]
        mode_q == MODE_SETTLE && mode_d == MODE_SEEK |-> scnt_q == settle_target - 16'h1)
        else $error("Settle period length wrong");
    AST_FALL_START: assert property (@(posedge clk) disable iff (sys_rst) // see [R10]
        $rose(rx_active) |-> !data_out && $past(samp_q) && !$past(dem_in)
        && $past(extended_tick))
        else $error("Stream did not start on a falling edge");
    AST_STAY: assert property (@(posedge clk) disable iff (sys_rst) // see [R11]
        rx_active && enable_pin |=> rx_active)
        else $error("Left receiving while enabled");
    AST_OUT_ON_XTICK: assert property (@(posedge clk) disable iff (sys_rst) // see [R12]
        rx_active && $past(rx_active) && $changed(data_out) |-> $past(extended_tick))
        else $error("Output changed off the extended tick");
    AST_MIN_GAP: assert property (@(posedge clk) disable iff (sys_rst) // see [R13]
        rx_active && $past(rx_active) && data_out != dprev_q
        |-> xsince_q >= 8'(MIN_GAP_XT))
        else $error("Output edges closer than the minimum gap");
endmodule

// [testbench/ardt_mcu_model.sv]
// Microcontroller and transmitter stand-in on the far side of the receiver pins
module ardt_mcu_model (
    input wire logic clk,
    input wire logic data_out,
    input wire logic extended_tick,
    output logic enable_pin,
    output logic freq_plan,
    output logic rate_sel_lo,
    output logic rate_sel_hi,
    output logic dem_in,
    output logic [15:0] gap_clk,
    output logic [15:0] edge_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] run_q;
    logic last_q;
    initial begin
        enable_pin = 1'b0;
        freq_plan = 1'b0;
        rate_sel_lo = 1'b0;
        rate_sel_hi = 1'b0;
        dem_in = 1'b1;
        gap_clk = 16'h0000;
        edge_cnt = 16'h0000;
        run_q = 16'h0000;
        last_q = 1'b1;
    end
    // ==========================================================
    // Control pins
    task automatic set_pins(input logic en, input logic plan, input logic [1:0] rng);
        @(posedge clk);
        enable_pin <= en;
        freq_plan <= plan;
        rate_sel_hi <= rng[1];
        rate_sel_lo <= rng[0];
    endtask
    // ==========================================================
    // Transmitter: edges launched on extended ticks, a whole number of ticks apart
    task automatic send_edges(input int n, input int gap_xt);
        for (int i = 0; i < n; i++) begin
            for (int k = 0; k < gap_xt; k++) begin
                @(posedge clk);
                while (extended_tick !== 1'b1) @(posedge clk);
            end
            dem_in <= ~dem_in;
        end
    endtask
    // Used only where no extended tick runs, e.g. in sleep
    task automatic flip();
        dem_in <= ~dem_in;
    endtask
    // ==========================================================
    // Decoder: measures every data interval in clocks, like a capture timer
    always @(posedge clk) begin
        if (data_out !== last_q) begin
            gap_clk <= run_q + 16'h0001;
            edge_cnt <= edge_cnt + 16'h0001;
            run_q <= 16'h0000;
        end else begin
            run_q <= run_q + 16'h0001;
        end
        last_q <= data_out;
    end
endmodule

// [testbench/testbench.sv]
// Self-checking bench of the receiver data timing block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ardt_pkg::*;
    logic clk, sys_rst, reg_wr, reg_rd, act_q, dout_q, xt_q;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic enable_pin, freq_plan, rate_sel_lo, rate_sel_hi, dem_in;
    logic data_out, rx_active, base_tick, extended_tick;
    logic [15:0] gap_clk, edge_cnt;
    int n_fail, total_checks, xt_cnt;
    // Short settle keeps the run brief: 20 half ticks, 100 clocks at divide by 10
    ardt_rx_timing #(.SETTLE_HALF_0(12'h014), .SETTLE_HALF_1(12'h014),
        .SETTLE_HALF_2(12'h014), .SETTLE_HALF_3(12'h014)) dut (.clk(clk), .sys_rst(sys_rst),
        .enable_pin(enable_pin), .freq_plan(freq_plan), .rate_sel_lo(rate_sel_lo),
        .rate_sel_hi(rate_sel_hi), .dem_in(dem_in), .data_out(data_out),
        .rx_active(rx_active), .base_tick(base_tick), .extended_tick(extended_tick),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    ardt_mcu_model mdl (.clk(clk), .data_out(data_out), .extended_tick(extended_tick),
        .enable_pin(enable_pin), .freq_plan(freq_plan), .rate_sel_lo(rate_sel_lo),
        .rate_sel_hi(rate_sel_hi), .dem_in(dem_in), .gap_clk(gap_clk), .edge_cnt(edge_cnt));
    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Clocks between two pulses of the extended or the base tick
    task automatic period(input bit xt, output int n);
        @(posedge clk);
        while ((xt ? extended_tick : base_tick) !== 1'b1) @(posedge clk);
        @(posedge clk);
        n = 1;
        while ((xt ? extended_tick : base_tick) !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic drain(output int cnt);
        logic [31:0] w;
        cnt = 0;
        reg_read(OFS_EDGE, w);
        while (w[EDGE_VALID] === 1'b1 && cnt < 12) begin
            cnt++;
            reg_read(OFS_EDGE, w);
        end
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [31:0] d;
        reg_read(OFS_CTRL, d);
        check(d, 32'h0);
        reg_read(OFS_STATUS, d);
        check(d, 32'h10);
        reg_read(4'hC, d);
        check(d, 32'h0);
        check(32'(rx_active), 32'h0);
    endtask
    task automatic t_base_tick();
        int n;
        for (int p = 0; p < 2; p++) begin
            mdl.set_pins(1'b0, p[0], 2'h0);
            period(1'b0, n);
            period(1'b0, n);
            check(n, (p == 0) ? 32'd10 : 32'd14);
        end
        mdl.set_pins(1'b0, 1'b0, 2'h0);
    endtask
    task automatic t_range_decode();
        logic [31:0] d;
        logic [1:0] exp [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
        for (int r = 0; r < 4; r++) begin
            mdl.set_pins(1'b0, 1'b0, r[1:0]);
            reg_read(OFS_STATUS, d);
            check(d, {27'h0, 1'b1, exp[r], 2'b00});
        end
    endtask
    task automatic t_wake();
        logic [31:0] d;
        int i;
        mdl.set_pins(1'b1, 1'b0, 2'h0);
        repeat (90) @(posedge clk);
        reg_read(OFS_STATUS, d);
        check(32'(d[1:0]), 32'(MODE_SETTLE));
        check(32'(rx_active), 32'h0);
        repeat (20) @(posedge clk);
        reg_read(OFS_STATUS, d);
        check(32'(d[1:0]), 32'(MODE_SEEK));
        repeat (200) @(posedge clk);
        check({data_out, rx_active}, 32'h2);
        mdl.send_edges(1, 1);
        for (i = 0; i < 200 && rx_active !== 1'b1; i++) @(posedge clk);
        check(32'(rx_active), 32'h1);
        check(32'(data_out), 32'h0);
    endtask
    task automatic t_xt_period();
        int n;
        logic [31:0] d;
        int exp [4] = '{80, 40, 20, 20};
        for (int r = 0; r < 4; r++) begin
            mdl.set_pins(1'b1, 1'b0, r[1:0]);
            period(1'b1, n);
            period(1'b1, n);
            check(n, exp[r]);
        end
        reg_write(OFS_CTRL, 32'h1);
        period(1'b1, n);
        period(1'b1, n);
        check(n, 32'd10);
        reg_read(OFS_CTRL, d);
        check(d, 32'h1);
        reg_write(OFS_CTRL, 32'h0);
        mdl.set_pins(1'b1, 1'b0, 2'h0);
    endtask
    task automatic t_shaping();
        int c;
        logic [31:0] w;
        logic [15:0] e;
        drain(c);
        mdl.send_edges(2, 3);
        repeat (100) @(posedge clk);
        check(32'(gap_clk), 32'd240);
        reg_read(OFS_EDGE, w);
        check(w & 32'h18000, 32'h18000);
        reg_read(OFS_EDGE, w);
        check(w, 32'h00010003);
        // A one-tick spike right after a passed edge must vanish
        e = edge_cnt;
        mdl.send_edges(1, 3);
        mdl.send_edges(2, 1);
        repeat (400) @(posedge clk);
        check(32'(edge_cnt), 32'(e) + 1);
    endtask
    task automatic t_overflow();
        int c;
        logic [31:0] d;
        logic [15:0] e;
        drain(c);
        e = edge_cnt;
        mdl.send_edges(11, 2);
        repeat (100) @(posedge clk);
        check(32'(edge_cnt), 32'(e) + 11);
        reg_read(OFS_STATUS, d);
        check(d & 32'h60, 32'h60);
        drain(c);
        check(c, 32'd9);
        reg_write(OFS_STATUS, 32'h20);
        reg_read(OFS_STATUS, d);
        check(d & 32'h60, 32'h0);
    endtask
    task automatic t_sleep();
        int n;
        logic [31:0] d;
        check(32'(rx_active), 32'h1);
        mdl.set_pins(1'b0, 1'b0, 2'h0);
        repeat (2) @(posedge clk);
        check({data_out, rx_active}, 32'h2);
        mdl.flip();
        n = 0;
        repeat (300) begin
            @(posedge clk);
            if (extended_tick === 1'b1) n++;
        end
        check(n, 32'd0);
        check(32'(data_out), 32'h1);
        reg_read(OFS_STATUS, d);
        check(32'(d[1:0]), 32'(MODE_SLEEP));
    endtask
    // ==========================================================
    // Output edge monitor: edges follow a tick and keep the least gap
    always @(posedge clk) begin
        if (extended_tick === 1'b1) xt_cnt <= xt_cnt + 1;
        // Every output edge restarts the count, the one that opens the stream too
        if (data_out !== dout_q) xt_cnt <= 0;
        if (act_q === 1'b1 && rx_active === 1'b1 && data_out !== dout_q) begin
            check(32'(xt_q), 32'h1);
            check(32'(xt_cnt >= 32'(MIN_GAP_XT)), 32'h1);
        end
        act_q <= rx_active;
        dout_q <= data_out;
        xt_q <= extended_tick;
    end
    // The whole sequence needs under 10000 clocks; 60000 means a hang
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        test_done();
    end
    initial begin
        n_fail = 0;
        total_checks = 0;
        xt_cnt = 0;
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_base_tick();
        t_range_decode();
        t_wake();
        t_xt_period();
        t_shaping();
        t_overflow();
        t_sleep();
        test_done();
    end
endmodule
